// ==== hdl/smpi_cfg.svh ====
// constants for the management-mode pin interface
// assumes inclusion by the core design module only
`ifndef SMPI_CFG_SVH
`define SMPI_CFG_SVH
`define SMPI_SEL_BIT 3
`define SMPI_SEL_RST 1'b0
`define SMPI_LOCK_RST 1'b0
`define SMPI_EN_RST 1'b0
`define SMPI_TRAP_LEAD 3
`define SMPI_CNT_W 2
`endif

// ==== hdl/smpi_pkg.sv ====
// types shared by the management-mode pin interface
// assumes the cfg header sits beside it
package smpi_pkg;
  typedef enum logic [2:0] {
    SMPI_IDLE = 3'b001,
    SMPI_SVC = 3'b010,
    SMPI_SW = 3'b100
  } smpi_state_t;

  // ctrl write from core: reg three value and strobe
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } smpi_cfg_wr_t;

  // core-side status of the interface
  typedef struct packed {
    logic legacy;
    logic locked;
    logic enabled;
    logic in_service;
  } smpi_status_t;
endpackage : smpi_pkg

// ==== hdl/smpi_sync.sv ====
// two-flop synchroniser for pin inputs
// assumes async active-high reset, inputs from outside clk domain
`timescale 1ns/1ns
module smpi_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  always_comb
  begin
    s1_nxt = d;
    s2_nxt = s1_r;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_r <= '1;
      s2_r <= '1;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q = s2_r;
endmodule : smpi_sync

// ==== hdl/smpi_core.sv ====
// management-mode pin interface: mode select, lock, pin direction/function
// assumes the core supplies service-routine and bus-cycle status on clk
//
// Behaviour
// RQ1: legacy mode disables space and memory access controls
// RQ2: legacy active output ignores out-of-region accesses
// RQ3: software avoids entry instruction in legacy mode
// RQ4: native mode: interrupt pin bidirectional, sampled each edge
// RQ5: native drives interrupt during service or entry
// RQ6: legacy interrupt pin input only, sampled each edge
// RQ7: legacy requests detected on falling edge
// RQ8: trap I/O cycle if asserted three clocks earlier
// RQ9: native shared pin is management address strobe
// RQ10: legacy shared pin held active through service routine
// RQ11: select bit three of reg three, resets native
// RQ12: lock freezes select and lock until reset
// RQ13: pins disabled after reset until software enables
// RQ14: pin functions switch only outside service routine
`timescale 1ns/1ns
`include "smpi_cfg.svh"
module smpi_core (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // configuration from core
  input wire smpi_pkg::smpi_cfg_wr_t cfg_wr,
  input wire logic lock_set,
  input wire logic pins_enable,
  input wire logic space_ctl_in,
  input wire logic mem_ctl_in,
  // core execution status
  input wire logic svc_active,
  input wire logic entry_instr,
  input wire logic mgmt_mem_cycle,
  input wire logic io_cycle,
  // external ready strobes, active low
  input wire logic rdy_n,
  input wire logic burst_ready_n,
  // interrupt pin, open-drain style
  input wire logic mgmt_interrupt_pin_i,
  output logic mgmt_interrupt_pin_o,
  output logic mgmt_interrupt_pin_oe_n,
  // shared strobe/active pin
  output logic mgmt_shared_pin_n,
  output logic mgmt_shared_pin_oe_n,
  // results to core
  output logic mgmt_irq_req,
  output logic io_trap,
  output logic mgmt_space_access_ctl,
  output logic mgmt_mem_access_ctl,
  output smpi_pkg::smpi_status_t status
);
  import smpi_pkg::*;

  logic int_s;
  logic rdy_s;
  logic burst_rdy_s;

  smpi_sync #(.W(3)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({mgmt_interrupt_pin_i, rdy_n, burst_ready_n}),
    .q({int_s, rdy_s, burst_rdy_s})
  );

  // config state
  logic sel_r;
  logic sel_nxt;
  // applied select, follows sel_r only between routines
  logic sel_act_r;
  logic sel_act_nxt;
  logic lock_r;
  logic lock_nxt;
  logic en_r;
  logic en_nxt;

  always_comb
  begin
    sel_nxt = sel_r;
    lock_nxt = lock_r;
    en_nxt = en_r | pins_enable; // RQ13
    if (!lock_r) // RQ12
    begin
      if (cfg_wr.wr)
        sel_nxt = cfg_wr.data[`SMPI_SEL_BIT]; // RQ11
      if (lock_set)
        lock_nxt = 1'b1;
    end
    // applied function changes only with no routine running
    sel_act_nxt = svc_active ? sel_act_r : sel_r; // RQ14
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_r <= `SMPI_SEL_RST;
      sel_act_r <= `SMPI_SEL_RST;
      lock_r <= `SMPI_LOCK_RST;
      en_r <= `SMPI_EN_RST;
    end
    else
    begin
      sel_r <= sel_nxt;
      sel_act_r <= sel_act_nxt;
      lock_r <= lock_nxt;
      en_r <= en_nxt;
    end
  end

  // sequence state
  smpi_state_t st_r;
  smpi_state_t st_nxt;
  logic int_d_r;
  logic int_d_nxt;
  logic [`SMPI_CNT_W-1:0] lead_r;
  logic [`SMPI_CNT_W-1:0] lead_nxt;
  logic req_nxt;
  logic trap_nxt;
  logic ipin_o_nxt;
  logic ipin_oe_nxt;
  logic spin_nxt;
  logic spin_oe_nxt;
  logic sac_nxt;
  logic mac_nxt;
  smpi_status_t stat_nxt;

  function automatic logic ready_seen(input logic r, input logic b);
    ready_seen = !r || !b;
  endfunction : ready_seen

  always_comb
  begin
    st_nxt = st_r;
    int_d_nxt = int_s;
    lead_nxt = lead_r;
    req_nxt = 1'b0;
    trap_nxt = 1'b0;
    ipin_o_nxt = 1'b1;
    ipin_oe_nxt = 1'b1;
    spin_nxt = 1'b1;
    spin_oe_nxt = 1'b1;
    // count clocks the interrupt input is seen low
    if (int_s)
      lead_nxt = '0;
    else if (lead_r != `SMPI_CNT_W'(`SMPI_TRAP_LEAD))
      lead_nxt = lead_r + `SMPI_CNT_W'(1);
    case (st_r)
      SMPI_IDLE:
        if (svc_active)
          st_nxt = SMPI_SVC;
        else if (entry_instr && space_ctl_in && !sel_act_r)
          st_nxt = SMPI_SW;
      SMPI_SVC:
        if (!svc_active)
          st_nxt = SMPI_IDLE;
      SMPI_SW:
        st_nxt = svc_active ? SMPI_SVC : SMPI_IDLE;
      default:
        st_nxt = SMPI_IDLE;
    endcase
    if (en_r)
    begin
      if (sel_act_r)
      begin
        // legacy: interrupt pin input only
        req_nxt = int_d_r && !int_s; // RQ6 RQ7
        trap_nxt = io_cycle && ready_seen(rdy_s, burst_rdy_s)
          && lead_r == `SMPI_CNT_W'(`SMPI_TRAP_LEAD); // RQ8
        spin_oe_nxt = 1'b0;
        spin_nxt = !svc_active; // RQ10 RQ2
      end
      else
      begin
        req_nxt = !int_s && !svc_active && int_d_r; // RQ4
        if (st_nxt != SMPI_IDLE)
        begin
          ipin_o_nxt = 1'b0; // RQ5
          ipin_oe_nxt = 1'b0;
        end
        spin_oe_nxt = 1'b0;
        spin_nxt = !mgmt_mem_cycle; // RQ9
      end
    end
    sac_nxt = space_ctl_in && !sel_act_r; // RQ1
    mac_nxt = mem_ctl_in && !sel_act_r; // RQ1
    stat_nxt = '{legacy: sel_act_r, locked: lock_r, enabled: en_r,
                 in_service: st_r == SMPI_SVC};
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= SMPI_IDLE;
      int_d_r <= 1'b1;
      lead_r <= '0;
      mgmt_irq_req <= 1'b0;
      io_trap <= 1'b0;
      mgmt_interrupt_pin_o <= 1'b1;
      mgmt_interrupt_pin_oe_n <= 1'b1;
      mgmt_shared_pin_n <= 1'b1;
      mgmt_shared_pin_oe_n <= 1'b1;
      mgmt_space_access_ctl <= 1'b0;
      mgmt_mem_access_ctl <= 1'b0;
      status <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      int_d_r <= int_d_nxt;
      lead_r <= lead_nxt;
      mgmt_irq_req <= req_nxt;
      io_trap <= trap_nxt;
      mgmt_interrupt_pin_o <= ipin_o_nxt;
      mgmt_interrupt_pin_oe_n <= ipin_oe_nxt;
      mgmt_shared_pin_n <= spin_nxt;
      mgmt_shared_pin_oe_n <= spin_oe_nxt;
      mgmt_space_access_ctl <= sac_nxt;
      mgmt_mem_access_ctl <= mac_nxt;
      status <= stat_nxt;
    end
  end
endmodule : smpi_core

// ==== tb/smpi_chip.sv ====
// chipset model: interrupt request and ready strobe pins
// assumes bench raises requests just after a clock edge
`timescale 1ns/1ns
module smpi_chip (
  // requests from bench
  input wire logic irq,
  input wire logic rdy,
  // active low pins, pulled high when released
  output logic irq_n,
  output logic rdy_n
);
  assign irq_n = !irq;
  assign rdy_n = !rdy;
endmodule : smpi_chip

// ==== tb/smpi_monitor.sv ====
// assertions on the management pin interface ports
// assumes bind onto smpi_core, single clock domain
`timescale 1ns/1ns
module smpi_monitor (
  // clock, reset and watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic svc_active,
  input wire logic mgmt_mem_cycle,
  input wire logic mgmt_interrupt_pin_i,
  input wire logic mgmt_interrupt_pin_o,
  input wire logic mgmt_interrupt_pin_oe_n,
  input wire logic mgmt_shared_pin_n,
  input wire logic mgmt_shared_pin_oe_n,
  input wire logic mgmt_irq_req,
  input wire logic mgmt_space_access_ctl,
  input wire logic mgmt_mem_access_ctl,
  input wire smpi_pkg::smpi_status_t status
);
  import smpi_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // legacy mode settled with pins on
  sequence leg_s;
    status.enabled && status.legacy && $stable(status.legacy);
  endsequence
  sequence leg_fall_s;
    leg_s ##0 $fell(mgmt_interrupt_pin_i);
  endsequence
  legacy_ctl_off_a: assert property (
    status.legacy [*2] |-> !mgmt_space_access_ctl && !mgmt_mem_access_ctl)
    else $error("access ctl on in legacy");
  native_drive_a: assert property (
    status.enabled && !status.legacy && svc_active
    |=> !mgmt_interrupt_pin_oe_n && !mgmt_interrupt_pin_o) else $error("native no drive");
  legacy_input_a: assert property (leg_s |-> mgmt_interrupt_pin_oe_n)
    else $error("legacy pin driven");
  fall_request_a: assert property (leg_fall_s |-> ##3 mgmt_irq_req ##1 !mgmt_irq_req)
    else $error("legacy request timing");
  native_strobe_a: assert property (
    status.enabled && !status.legacy && mgmt_mem_cycle |=> !mgmt_shared_pin_n)
    else $error("no strobe");
  legacy_active_a: assert property (
    leg_s ##0 svc_active |=> !mgmt_shared_pin_n && !mgmt_shared_pin_oe_n)
    else $error("active not held");
  lock_hold_a: assert property (status.locked [*3] |-> $stable(status.legacy))
    else $error("locked select moved");
  pins_off_a: assert property (
    !status.enabled |-> mgmt_interrupt_pin_oe_n && mgmt_shared_pin_oe_n)
    else $error("pins driven while off");
endmodule : smpi_monitor
bind smpi_core smpi_monitor mon (.*);

// ==== tb/testbench.sv ====
// bench for the management pin interface
// assumes chipset model and checker compiled first
`timescale 1ns/1ns
module testbench;
  import smpi_pkg::*;
  logic clk = 0, sys_rst = 1, lock_set = 0, pins_enable = 0, space_ctl_in = 1;
  logic mem_ctl_in = 1, svc_active = 0, entry_instr = 0, mgmt_mem_cycle = 0, io_cycle = 0;
  logic burst_ready_n = 1, irq = 0, rdy = 0, irq_n, rdy_n, mgmt_interrupt_pin_o;
  logic mgmt_interrupt_pin_oe_n, mgmt_shared_pin_n, mgmt_shared_pin_oe_n, mgmt_irq_req;
  logic io_trap, mgmt_space_access_ctl, mgmt_mem_access_ctl;
  smpi_cfg_wr_t cfg_wr = '0;
  smpi_status_t status;
  int fails = 0, samples_checked = 0, hits;
  wire mgmt_interrupt_pin_i = irq_n & (mgmt_interrupt_pin_oe_n | mgmt_interrupt_pin_o);
  always #2 clk = !clk;
  smpi_chip chip (.irq, .rdy, .irq_n, .rdy_n);
  smpi_core dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .cfg_wr(cfg_wr),
    .lock_set(lock_set),
    .pins_enable(pins_enable),
    .space_ctl_in(space_ctl_in),
    .mem_ctl_in(mem_ctl_in),
    .svc_active(svc_active),
    .entry_instr(entry_instr),
    .mgmt_mem_cycle(mgmt_mem_cycle),
    .io_cycle(io_cycle),
    .rdy_n(rdy_n),
    .burst_ready_n(burst_ready_n),
    .mgmt_interrupt_pin_i(mgmt_interrupt_pin_i),
    .mgmt_interrupt_pin_o(mgmt_interrupt_pin_o),
    .mgmt_interrupt_pin_oe_n(mgmt_interrupt_pin_oe_n),
    .mgmt_shared_pin_n(mgmt_shared_pin_n),
    .mgmt_shared_pin_oe_n(mgmt_shared_pin_oe_n),
    .mgmt_irq_req(mgmt_irq_req),
    .io_trap(io_trap),
    .mgmt_space_access_ctl(mgmt_space_access_ctl),
    .mgmt_mem_access_ctl(mgmt_mem_access_ctl),
    .status(status)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic count(input int n, input bit trap);
    hits = 0;
    repeat (n)
    begin
      tick(1);
      hits += trap ? io_trap : mgmt_irq_req;
    end
  endtask : count
  task automatic wr_sel(input logic [7:0] d);
    cfg_wr = {1'b1, d};
    tick(1);
    cfg_wr.wr = 0;
    tick(2);
  endtask : wr_sel
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic t_reset;
    irq = 1;
    count(6, 0);
    check(8'(hits), 0);
    check({status, mgmt_interrupt_pin_oe_n, mgmt_shared_pin_oe_n}, 8'h03);
    irq = 0;
    tick(3);
  endtask : t_reset
  task automatic t_native;
    pins_enable = 1;
    tick(1);
    pins_enable = 0;
    irq = 1;
    count(4, 0);
    check(8'(hits), 1);
    irq = 0;
    svc_active = 1;
    mgmt_mem_cycle = 1;
    tick(3);
    check({mgmt_interrupt_pin_i, mgmt_shared_pin_n, mgmt_space_access_ctl}, 8'h01);
    check(mgmt_mem_access_ctl, 1);
    svc_active = 0;
    mgmt_mem_cycle = 0;
    tick(3);
    entry_instr = 1;
    tick(1);
    entry_instr = 0;
    check(mgmt_interrupt_pin_oe_n, 0);
    svc_active = 1;
    tick(2);
    svc_active = 0;
    tick(3);
  endtask : t_native
  task automatic t_legacy;
    wr_sel(8'h08);
    check({status.legacy, mgmt_space_access_ctl, mgmt_mem_access_ctl}, 8'h04);
    irq = 1;
    count(8, 0);
    check(8'(hits), 1);
    {io_cycle, rdy} = 2'b11;
    count(4, 1);
    check(8'(hits > 0), 1);
    {irq, rdy, io_cycle} = 0;
    tick(3);
    {irq, rdy, io_cycle} = 3'b111;
    count(3, 1);
    check(8'(hits), 0);
    {irq, rdy, io_cycle} = 0;
    svc_active = 1;
    tick(2);
    check({mgmt_shared_pin_n, mgmt_shared_pin_oe_n, mgmt_interrupt_pin_oe_n}, 8'h01);
    mgmt_mem_cycle = 1;
    wr_sel(8'h00);
    check({mgmt_shared_pin_n, status.legacy}, 8'h01);
    {svc_active, mgmt_mem_cycle} = 0;
    tick(3);
  endtask : t_legacy
  task automatic t_lock;
    wr_sel(8'h08);
    lock_set = 1;
    tick(1);
    lock_set = 0;
    wr_sel(8'h00);
    check({status.legacy, status.locked}, 8'h03);
    sys_rst = 1;
    tick(2);
    sys_rst = 0;
    tick(1);
    check(status, 0);
  endtask : t_lock
  initial
  begin
    tick(5);
    sys_rst = 0;
    t_reset;
    t_native;
    t_legacy;
    t_lock;
    give_verdict;
  end
  initial
  begin
    #4000;
    fails++;
    give_verdict;
  end
endmodule : testbench
